/* File: logic/pin_mux_pkg.sv */
// constants shared by the first-port alternate function override logic
// assumes a single system clock domain and an active-high chip reset
package pin_mux_pkg;

  // port geometry
  localparam int PORT_A_WIDTH   = 8;
  localparam int PORT_B_WIDTH   = 4;
  localparam int PINCHG_WIDTH   = 12;

  // pin positions on the first port
  localparam int BIT_AREF       = 0;
  localparam int BIT_CMP_NEG    = 2;
  localparam int BIT_T0_COUNT   = 3;
  localparam int BIT_SER_CLOCK  = 4;
  localparam int BIT_SER_DOUT   = 5;
  localparam int BIT_SER_DATA   = 6;
  localparam int BIT_CAPTURE    = 7;

  // pin position on the second port carrying the clock image
  localparam int BIT_PB_SYS_CLOCK_OUTPUT   = 2;

  // pin-change source numbers of the second port start here
  localparam int PINCHG_B_BASE  = 8;
  localparam int PINCHG_PB2_SRC = 10;

  // reset values of the port registers, the input synchronisers and the gated inputs
  localparam logic [7:0] PORT_OUT_RESET = 8'h00;
  localparam logic [7:0] PORT_DIR_RESET = 8'h00;
  localparam logic [3:0] PB_SYNC_RESET  = 4'h0;
  localparam logic [7:0] PA_SYNC_RESET  = 8'h00;
  localparam logic [11:0] DIN_RESET     = 12'h000;

  // serial wire mode encodings {hi, lo}
  localparam logic [1:0] WIRE_MODE_OFF   = 2'h0;
  localparam logic [1:0] WIRE_MODE_THREE = 2'h1;

endpackage

/* File: logic/pin_ovr_cell.sv */
// one pad of a general-purpose port with its override hooks applied
// assumes the override signals are stable logic on ref_clk
`timescale 1ns/1ps

module pin_ovr_cell (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic port_bit,
  input  wire logic dir_bit,
  input  wire logic pud,
  input  wire logic normal_din_en,
  input  wire logic pullup_ovr_en,
  input  wire logic pullup_ovr_val,
  input  wire logic dir_ovr_en,
  input  wire logic dir_ovr_val,
  input  wire logic value_ovr_en,
  input  wire logic value_ovr_val,
  input  wire logic din_ovr_en,
  input  wire logic din_ovr_val,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pullup_en,
  output logic      din_en
);

  logic oe_nxt;
  logic out_nxt;
  logic pu_nxt;
  logic din_nxt;

  // driver enable, then value; value is parked low while not driving
  assign oe_nxt  = dir_ovr_en ? dir_ovr_val : dir_bit;
  assign out_nxt = (value_ovr_en ? value_ovr_val : port_bit) & oe_nxt;
  // pull-up follows the effective direction so a forced input keeps it
  assign pu_nxt  = pullup_ovr_en ? pullup_ovr_val
                 : (~oe_nxt & port_bit & ~pud);
  assign din_nxt = din_ovr_en ? din_ovr_val : normal_din_en;

  // registered pad controls so the pad never sees decode glitches
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pad_out   <= 1'b0;
      pad_oe    <= 1'b0;
      pullup_en <= 1'b0;
      din_en    <= 1'b0;
    end else begin
      pad_out   <= out_nxt;
      pad_oe    <= oe_nxt;
      pullup_en <= pu_nxt;
      din_en    <= din_nxt;
    end
  end

endmodule

/* File: logic/port_alt_function_override.sv */
// alternate function override logic for the eight first-port pins,
// plus the pin-change and clock-out routing of the second port
// assumes peripherals, pads and port registers share ref_clk; pad
// inputs arrive asynchronously and are synchronised here
`timescale 1ns/1ps

// Operation
// - value override replaces output bit when driving
// - direction override sets driver enable
// - input override sets digital input enable
// - toggle override inverts output bit; bit4 serial
// - three-wire mode drives serial output on bit5 when output
// - bit5 pull-up follows output bit when input
// - bit5 value: serial output else compare B
// - spi master forces bit5 to input
// - forced spi inputs keep pull-up from output bit
// - spi slave forces bit6 to input
// - compare B on bit5 needs direction bit
// - compare A on bit6 needs direction; two-wire suppresses
// - bit7 drives timer0 compare B when output
// - two-wire open-drain data enable on bit6
// - pin-change or analog disable overrides input enable
// - start detect keeps bit4 and bit6 inputs on
// - analog reference disables bit0 pad outside reset
// - bit3 counts timer0, bit4 counts timer1
// - bit7 feeds timer1 capture
// - pin-change sources 0-7 port A, 8-11 port B
// - second-port bit2 interrupt, compare A, clock, pin-change
module port_alt_function_override (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        pud,
  input  wire logic        normal_din_en,
  input  wire logic        port_wr_en,
  input  wire logic [7:0]  port_wr_data,
  input  wire logic        dir_wr_en,
  input  wire logic [7:0]  dir_wr_data,
  input  wire logic        serial_wire_mode_hi,
  input  wire logic        serial_wire_mode_lo,
  input  wire logic        start_detect_irq_en,
  input  wire logic        serial_clock_hold,
  input  wire logic        serial_clock_toggle,
  input  wire logic        serial_data_out,
  input  wire logic        serial_sda_out,
  input  wire logic        spi_en,
  input  wire logic        spi_master,
  input  wire logic        timer1_compare_a_out,
  input  wire logic        timer1_compare_a_en,
  input  wire logic        timer1_compare_b_out,
  input  wire logic        timer1_compare_b_en,
  input  wire logic        timer0_compare_b_out,
  input  wire logic        timer0_compare_b_en,
  input  wire logic        timer0_compare_a_out,
  input  wire logic        timer0_compare_a_en,
  input  wire logic        ref_select_hi,
  input  wire logic        ref_select_lo,
  input  wire logic [7:0]  analog_din_disable,
  input  wire logic        pinchg_group_a_en,
  input  wire logic        pinchg_group_b_en,
  input  wire logic [11:0] pinchg_mask_bit,
  input  wire logic        ext_irq_zero_en,
  input  wire logic        sys_clock_output_en,
  input  wire logic        pb2_port_bit,
  input  wire logic        pb2_dir_bit,
  input  wire logic [7:0]  pa_pin_in,
  input  wire logic [3:0]  pb_pin_in,
  output logic [7:0]       pa_pad_out,
  output logic [7:0]       pa_pad_oe,
  output logic [7:0]       pa_pullup_en,
  output logic [7:0]       pa_din_en,
  output logic             pb2_pad_out,
  output logic             pb2_pad_oe,
  output logic             pb2_pullup_en,
  output logic [7:0]       port_out_val,
  output logic [7:0]       dir_val,
  output logic             timer0_ext_count_in,
  output logic             timer1_ext_count_in,
  output logic             timer1_capture_in,
  output logic             serial_data_in,
  output logic             serial_wire_clock,
  output logic             ext_irq_zero_in,
  output logic [11:0]      pinchg_src
);

  logic [7:0]  port_out_r;
  logic [7:0]  port_out_nxt;
  logic [7:0]  dir_r;
  logic [7:0]  dir_nxt;
  logic        in_reset_r;
  logic        clk_phase_r;
  logic [7:0]  pa_meta_r;
  logic [7:0]  pa_sync_r;
  logic [3:0]  pb_meta_r;
  logic [3:0]  pb_sync_r;
  logic [11:0] din_r;
  logic [11:0] din_nxt;
  logic [3:0]  pb_din_en;
  logic        pb2_din_en;

  logic        three_wire;
  logic        two_wire;
  logic        spi_master_on;
  logic        spi_slave_on;
  logic        aref_on;
  logic        sda_drive;
  logic        scl_drive;
  logic        timer1_compare_a_out_free;
  logic        bit5_val;
  logic [7:0]  toggle_ovr_en;
  logic [7:0]  pullup_ovr_en;
  logic [7:0]  pullup_ovr_val;
  logic [7:0]  dir_ovr_en;
  logic [7:0]  dir_ovr_val;
  logic [7:0]  value_ovr_en;
  logic [7:0]  value_ovr_val;
  logic [7:0]  din_ovr_en;
  logic [7:0]  din_ovr_val;
  logic [7:0]  pc_hit;
  logic [7:0]  start_hold;
  logic [3:0]  pb_pc_hit;

  // wire mode decode; the lo-and-hi code also counts as two-wire
  assign three_wire = ({serial_wire_mode_hi, serial_wire_mode_lo}
                       == pin_mux_pkg::WIRE_MODE_THREE);
  assign two_wire   = serial_wire_mode_hi;
  assign spi_master_on = spi_en & spi_master;
  assign spi_slave_on  = spi_en & ~spi_master;

  // reference select bars lost: only ref_select_lo picks the pin,
  // whichever way ref_select_hi stands
  assign aref_on = ~in_reset_r & ref_select_lo;

  // open-drain style: drive low while the serial side or the port
  // bit pulls low, never drive high
  assign sda_drive = (~serial_sda_out | ~port_out_r[6]) & dir_r[6];
  assign scl_drive = (serial_clock_hold | ~port_out_r[4])
                     & dir_r[4];
  assign timer1_compare_a_out_free = ~(two_wire & dir_r[6]);
  assign bit5_val  = three_wire ? serial_data_out
                   : timer1_compare_b_out;

  // on the first port, pull-up overrides only exist on the reference pin
  assign pullup_ovr_en  = {7'h00, aref_on};
  assign pullup_ovr_val = 8'h00;

  // spi slave forcing wins over two-wire on the shared data pin, bit6
  assign dir_ovr_en = {1'b0, spi_slave_on | two_wire, spi_master_on,
                       two_wire, 3'h0, aref_on};
  assign dir_ovr_val = {1'b0, ~spi_slave_on & sda_drive, 1'b0,
                        scl_drive, 4'h0};

  // compare outputs reach the pad only through the register direction
  assign value_ovr_en = {timer0_compare_b_en,
                         (two_wire & dir_r[6]) | timer1_compare_a_en,
                         three_wire | timer1_compare_b_en,
                         two_wire & dir_r[4], 3'h0,
                         aref_on};
  assign value_ovr_val = {timer0_compare_b_out,
                          timer1_compare_a_out_free & timer1_compare_a_out,
                          bit5_val, 5'h00};

  // digital input enable overrides
  assign pc_hit     = pinchg_mask_bit[7:0] & {8{pinchg_group_a_en}};
  assign start_hold = {1'b0, start_detect_irq_en, 1'b0,
                       start_detect_irq_en, 4'h0};
  assign din_ovr_en  = pc_hit | analog_din_disable | start_hold;
  assign din_ovr_val = pc_hit | start_hold;

  // only the serial clock pin has a toggle source
  assign toggle_ovr_en = {3'h0, serial_clock_toggle, 4'h0};

  // a write lands first, the toggle then flips the freshly written bit
  assign port_out_nxt = (port_wr_en ? port_wr_data : port_out_r)
                        ^ toggle_ovr_en;
  assign dir_nxt = dir_wr_en ? dir_wr_data : dir_r;

  // port output and direction registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      port_out_r <= pin_mux_pkg::PORT_OUT_RESET;
      dir_r      <= pin_mux_pkg::PORT_DIR_RESET;
    end else begin
      port_out_r <= port_out_nxt;
      dir_r      <= dir_nxt;
    end
  end

  // reset flag for the reference pin; the clock image is a half-rate
  // square wave since the real clock may not pass through logic
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      in_reset_r  <= 1'b1;
      clk_phase_r <= 1'b0;
    end else begin
      in_reset_r  <= 1'b0;
      clk_phase_r <= ~clk_phase_r;
    end
  end

  // pad inputs are asynchronous: two flops before anything reads them
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pa_meta_r <= pin_mux_pkg::PA_SYNC_RESET;
      pa_sync_r <= pin_mux_pkg::PA_SYNC_RESET;
      pb_meta_r <= pin_mux_pkg::PB_SYNC_RESET;
      pb_sync_r <= pin_mux_pkg::PB_SYNC_RESET;
    end else begin
      pa_meta_r <= pa_pin_in;
      pa_sync_r <= pa_meta_r;
      pb_meta_r <= pb_pin_in;
      pb_sync_r <= pb_meta_r;
    end
  end

  // one override cell per first-port pin
  genvar gi;
  generate
    for (gi = 0; gi < pin_mux_pkg::PORT_A_WIDTH; gi++) begin : g_pa
      pin_ovr_cell u_cell (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .port_bit       (port_out_r[gi]),
        .dir_bit        (dir_r[gi]),
        .pud            (pud),
        .normal_din_en  (normal_din_en),
        .pullup_ovr_en  (pullup_ovr_en[gi]),
        .pullup_ovr_val (pullup_ovr_val[gi]),
        .dir_ovr_en     (dir_ovr_en[gi]),
        .dir_ovr_val    (dir_ovr_val[gi]),
        .value_ovr_en   (value_ovr_en[gi]),
        .value_ovr_val  (value_ovr_val[gi]),
        .din_ovr_en     (din_ovr_en[gi]),
        .din_ovr_val    (din_ovr_val[gi]),
        .pad_out        (pa_pad_out[gi]),
        .pad_oe         (pa_pad_oe[gi]),
        .pullup_en      (pa_pullup_en[gi]),
        .din_en         (pa_din_en[gi])
      );
    end
  endgenerate

  // second-port bit 2: clock image beats compare A when enabled
  pin_ovr_cell u_pb2 (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .port_bit       (pb2_port_bit),
    .dir_bit        (pb2_dir_bit),
    .pud            (pud),
    .normal_din_en  (normal_din_en),
    .pullup_ovr_en  (sys_clock_output_en),
    .pullup_ovr_val (1'b0),
    .dir_ovr_en     (sys_clock_output_en),
    .dir_ovr_val    (1'b1),
    .value_ovr_en   (sys_clock_output_en | timer0_compare_a_en),
    .value_ovr_val  (sys_clock_output_en ? clk_phase_r
                     : timer0_compare_a_out),
    .din_ovr_en     (pb_pc_hit[2] | ext_irq_zero_en),
    .din_ovr_val    (pb_pc_hit[2] | ext_irq_zero_en),
    .pad_out        (pb2_pad_out),
    .pad_oe         (pb2_pad_oe),
    .pullup_en      (pb2_pullup_en),
    .din_en         (pb2_din_en)
  );

  // second-port input enables for the pins without drive overrides
  assign pb_pc_hit = pinchg_mask_bit[11:8] & {4{pinchg_group_b_en}};
  assign pb_din_en = {pb_pc_hit[3] | normal_din_en, pb2_din_en,
                      pb_pc_hit[1:0] | {2{normal_din_en}}};

  // gated digital inputs, one flop so consumers see clean levels
  assign din_nxt = {pb_sync_r & pb_din_en,
                    pa_sync_r & pa_din_en};
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      din_r <= pin_mux_pkg::DIN_RESET;
    end else begin
      din_r <= din_nxt;
    end
  end

  // routing of digital inputs to peripherals
  assign timer0_ext_count_in = din_r[pin_mux_pkg::BIT_T0_COUNT];
  assign timer1_ext_count_in = din_r[pin_mux_pkg::BIT_SER_CLOCK];
  assign serial_wire_clock   = din_r[pin_mux_pkg::BIT_SER_CLOCK];
  assign serial_data_in      = din_r[pin_mux_pkg::BIT_SER_DATA];
  assign timer1_capture_in   = din_r[pin_mux_pkg::BIT_CAPTURE];
  assign ext_irq_zero_in     = din_r[pin_mux_pkg::PINCHG_PB2_SRC];
  assign pinchg_src          = din_r;
  assign port_out_val        = port_out_r;
  assign dir_val             = dir_r;

  // checks on the pad controls
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_aref_pad_off: assert property (aref_on |=>
    !pa_pad_oe[0] && !pa_pullup_en[0] && !pa_pad_out[0])
    else $error("reference pin still drives");
  a_miso_forced_in: assert property (spi_master_on |=>
    !pa_pad_oe[5]) else $error("master spi left bit5 driving");
  a_mosi_forced_in: assert property (spi_slave_on |=>
    !pa_pad_oe[6]) else $error("slave spi left bit6 driving");
  a_three_wire_do: assert property (
    three_wire && dir_r[5] && !spi_en |=>
    pa_pad_oe[5] && pa_pad_out[5] == $past(serial_data_out))
    else $error("serial output not on bit5");
  a_bit5_pullup: assert property (
    three_wire && !dir_r[5] && port_out_r[5] && !pud |=>
    pa_pullup_en[5]) else $error("bit5 pull-up lost");
  a_cmpb_needs_dir: assert property (!dir_r[5] |=>
    !pa_pad_oe[5]) else $error("bit5 drives without direction");
  a_toggle_flips: assert property (
    serial_clock_toggle && !port_wr_en |=>
    port_out_r[4] != $past(port_out_r[4]))
    else $error("clock toggle did not flip bit4");
  a_scl_open_drain: assert property (
    two_wire |=> !pa_pad_out[4] && pa_pad_oe[4] ==
    $past((serial_clock_hold || !port_out_r[4]) && dir_r[4]))
    else $error("two-wire clock drive wrong");
  a_start_din_on: assert property (start_detect_irq_en |=>
    pa_din_en[4] && pa_din_en[6]) else $error("start inputs off");
  // the enable may drop after its first cycle, so the routed level is
  // only owed while the registered enable that gated it was still on
  a_pinchg_route: assert property (
    pc_hit[3] && !analog_din_disable[3] |=> pa_din_en[3] ##2
    (!$past(pa_din_en[3]) ||
     timer0_ext_count_in == $past(pa_pin_in[3], 3)))
    else $error("pin-change input not routed");
  a_clock_out_pin: assert property (
    sys_clock_output_en ##1 sys_clock_output_en |=> pb2_pad_oe &&
    !pb2_pullup_en && pb2_pad_out != $past(pb2_pad_out))
    else $error("clock image missing on second port bit2");

  c_three_wire: cover property (three_wire && dir_r[5] ##1 pa_pad_oe[5]);
  c_two_wire_hold: cover property (two_wire && serial_clock_hold
    && dir_r[4] ##1 pa_pad_oe[4]);
  c_aref_release: cover property (aref_on ##1 !aref_on);
  c_spi_master: cover property (spi_master_on && dir_r[5] ##1 !pa_pad_oe[5]);
  c_clock_out: cover property (sys_clock_output_en ##2 pb2_pad_out);

endmodule

/* File: verification/pad_far_side.sv */
// far side of the first-port pads: outside drivers and the wire itself
// assumes the bench sets which pins an outside source drives and how
`timescale 1ns/1ps

module pad_far_side (
  input  wire logic       ref_clk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pullup_en,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_level
);
  logic [7:0] float_r = 8'h5a;

  // an undriven line without pull-up wanders each cycle, never a stale 0/1
  always_ff @(posedge ref_clk) begin
    float_r <= ~float_r;
  end

  // own pad wins over the weak outside source; then source, pull-up, float
  assign pin_level = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                   | (~pad_oe & ~ext_en & (pullup_en | float_r));
endmodule

/* File: verification/test_port_alt_function_override.sv */
// self-checking bench for the first-port override block against a model
// assumes one 100 MHz clock and a far-side pad model on the port A pins
`timescale 1ns/1ps

module test_port_alt_function_override;
  logic        ref_clk, rst, pud, normal_din_en, port_wr_en, dir_wr_en;
  logic [7:0]  port_wr_data, dir_wr_data, analog_din_disable, pa_pin_in;
  logic [7:0]  ext_en, ext_val, mport, mdir;
  logic [7:0]  exp_oe, exp_out, exp_pu, exp_din;
  logic        serial_wire_mode_hi, serial_wire_mode_lo, start_detect_irq_en;
  logic        serial_clock_hold, serial_clock_toggle, serial_data_out;
  logic        serial_sda_out, spi_en, spi_master, ref_select_hi;
  logic        timer1_compare_a_out, timer1_compare_a_en, timer1_compare_b_out;
  logic        timer1_compare_b_en, timer0_compare_b_out, timer0_compare_b_en;
  logic        timer0_compare_a_out, timer0_compare_a_en, ref_select_lo;
  logic        pinchg_group_a_en, pinchg_group_b_en, ext_irq_zero_en;
  logic        sys_clock_output_en, pb2_port_bit, pb2_dir_bit;
  logic [11:0] pinchg_mask_bit, pinchg_src;
  logic [3:0]  pb_pin_in;
  logic [7:0]  pa_pad_out, pa_pad_oe, pa_pullup_en, pa_din_en;
  logic [7:0]  port_out_val, dir_val;
  logic        pb2_pad_out, pb2_pad_oe, pb2_pullup_en, timer0_ext_count_in;
  logic        timer1_ext_count_in, timer1_capture_in, serial_data_in;
  logic        serial_wire_clock, ext_irq_zero_in;
  logic [31:0] seed_r;
  int          bad_count, check_count;

  port_alt_function_override dut (
    .ref_clk, .rst, .pud, .normal_din_en, .port_wr_en, .port_wr_data,
    .dir_wr_en, .dir_wr_data, .serial_wire_mode_hi, .serial_wire_mode_lo,
    .start_detect_irq_en, .serial_clock_hold, .serial_clock_toggle,
    .serial_data_out, .serial_sda_out, .spi_en, .spi_master,
    .timer1_compare_a_out, .timer1_compare_a_en, .timer1_compare_b_out,
    .timer1_compare_b_en, .timer0_compare_b_out, .timer0_compare_b_en,
    .timer0_compare_a_out, .timer0_compare_a_en, .ref_select_hi,
    .ref_select_lo, .analog_din_disable, .pinchg_group_a_en,
    .pinchg_group_b_en, .pinchg_mask_bit, .ext_irq_zero_en,
    .sys_clock_output_en, .pb2_port_bit, .pb2_dir_bit, .pa_pin_in,
    .pb_pin_in, .pa_pad_out, .pa_pad_oe, .pa_pullup_en, .pa_din_en,
    .pb2_pad_out, .pb2_pad_oe, .pb2_pullup_en, .port_out_val, .dir_val,
    .timer0_ext_count_in, .timer1_ext_count_in, .timer1_capture_in,
    .serial_data_in, .serial_wire_clock, .ext_irq_zero_in, .pinchg_src
  );

  pad_far_side far (
    .ref_clk, .pad_out(pa_pad_out), .pad_oe(pa_pad_oe),
    .pullup_en(pa_pullup_en), .ext_en, .ext_val, .pin_level(pa_pin_in)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] xs();
    seed_r = seed_r ^ (seed_r << 13);
    seed_r = seed_r ^ (seed_r >> 17);
    seed_r = seed_r ^ (seed_r << 5);
    return seed_r;
  endfunction

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // the random words land on every control input but reset, the write strobes and data, and the toggle at once
  task automatic apply(logic [31:0] a, logic [31:0] b, logic [31:0] c);
    {serial_wire_mode_hi, serial_wire_mode_lo, start_detect_irq_en,
     serial_clock_hold, serial_data_out, serial_sda_out, spi_en,
     spi_master} <= a[7:0];
    {timer1_compare_a_out, timer1_compare_a_en, timer1_compare_b_out,
     timer1_compare_b_en, timer0_compare_b_out, timer0_compare_b_en,
     timer0_compare_a_out, timer0_compare_a_en} <= a[15:8];
    {ref_select_hi, ref_select_lo, pud, normal_din_en, pinchg_group_a_en,
     pinchg_group_b_en, ext_irq_zero_en, sys_clock_output_en} <= a[23:16];
    {pb2_port_bit, pb2_dir_bit, pb_pin_in} <= a[29:24];
    analog_din_disable <= b[7:0] & b[15:8]; // sparse, so pin-change shows
    pinchg_mask_bit <= b[27:16];
    {ext_val, ext_en} <= c[15:0];
  endtask

  // expected pad controls from the override equations
  task automatic model();
    logic tw, th;
    logic [7:0] oe, val, en, st, ov;
    tw = serial_wire_mode_hi;
    th = ~serial_wire_mode_hi & serial_wire_mode_lo;
    oe = mdir;
    val = mport;
    if (spi_en && spi_master) oe[5] = 1'b0;
    if (spi_en && !spi_master) oe[6] = 1'b0;
    else if (tw) oe[6] = (~serial_sda_out | ~mport[6]) & mdir[6];
    if (tw) oe[4] = (serial_clock_hold | ~mport[4]) & mdir[4];
    if (ref_select_lo) oe[0] = 1'b0;
    if (tw && mdir[4]) val[4] = 1'b0;
    if (th) val[5] = serial_data_out;
    else if (timer1_compare_b_en) val[5] = timer1_compare_b_out;
    if (tw && mdir[6]) val[6] = 1'b0;
    else if (timer1_compare_a_en) val[6] = timer1_compare_a_out;
    if (timer0_compare_b_en) val[7] = timer0_compare_b_out;
    exp_oe = oe;
    exp_out = oe & val;
    exp_pu = ~oe & mport & {8{~pud}};
    if (ref_select_lo) exp_pu[0] = 1'b0;
    en = pinchg_mask_bit[7:0] & {8{pinchg_group_a_en}};
    st = start_detect_irq_en ? 8'h50 : 8'h00;
    ov = en | st | analog_din_disable;
    exp_din = (ov & (en | st)) | (~ov & {8{normal_din_en}});
  endtask

  task automatic compare_all();
    logic [7:0] known, lvl, src, m5;
    logic pv;
    model();
    known = exp_oe | ext_en | exp_pu;
    lvl = (exp_oe & exp_out) | (~exp_oe & ext_en & ext_val)
        | (~exp_oe & ~ext_en & exp_pu);
    src = exp_din & lvl;
    m5 = {3'h0, known[7], known[6], known[4], known[4], known[3]};
    pv = timer0_compare_a_en ? timer0_compare_a_out : pb2_port_bit;
    check("port_out_val", port_out_val, mport);
    check("dir_val", dir_val, mdir);
    check("pa_pad_oe", pa_pad_oe, exp_oe);
    check("pa_pad_out", pa_pad_out, exp_out);
    check("pa_pullup_en", pa_pullup_en, exp_pu);
    check("pa_din_en", pa_din_en, exp_din);
    check("pinchg_a", pinchg_src[7:0] & known, src & known);
    check("pinchg_b", {4'h0, pinchg_src[11:8]}, {4'h0, pb_pin_in
          & ({4{normal_din_en}} | {1'b0, ext_irq_zero_en, 2'h0}
          | (pinchg_mask_bit[11:8] & {4{pinchg_group_b_en}}))});
    check("timer_ins", m5 & {3'h0, timer1_capture_in, serial_data_in,
          serial_wire_clock, timer1_ext_count_in, timer0_ext_count_in},
          m5 & {3'h0, src[7], src[6], src[4], src[4], src[3]});
    if (ext_irq_zero_en) check("pb2_in", {6'h00, ext_irq_zero_in,
          pinchg_src[10]}, {6'h00, {2{pb_pin_in[2]}}});
    if (sys_clock_output_en) check("pb2_pad", {6'h00, pb2_pad_oe,
          pb2_pullup_en}, 8'h02);
    else check("pb2_pad", {5'h00, pb2_pad_oe, pb2_pad_out, pb2_pullup_en},
          {5'h00, pb2_dir_bit, pb2_dir_bit & pv,
           ~pb2_dir_bit & pb2_port_bit & ~pud});
  endtask

  // writes land one edge later, pads one more, synced inputs three more
  task automatic write_settle(logic [7:0] pv, logic [7:0] dv);
    @(posedge ref_clk);
    {port_wr_en, dir_wr_en, port_wr_data, dir_wr_data} <= {2'h3, pv, dv};
    mport = pv;
    mdir = dv;
    @(posedge ref_clk);
    {port_wr_en, dir_wr_en} <= 2'h0;
    repeat (8) @(posedge ref_clk);
    #1 compare_all();
  endtask

  // port A pad controls and the port registers must read zero after ten reset cycles whatever the inputs say
  task automatic do_reset();
    rst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    #1 check("reset_outs", pa_pad_out | pa_pad_oe | pa_pullup_en
          | pa_din_en | port_out_val | dir_val, 8'h00);
    @(posedge ref_clk);
    rst <= 1'b0;
    mport = 8'h00;
    mdir = 8'h00;
    $display("test reset done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // a hang past the expected run length counts as a failure
  initial begin
    #400000;
    bad_count++;
    wrap_up();
  end

  initial begin
    logic [31:0] w;
    seed_r = 32'h0000001e;
    {rst, port_wr_en, dir_wr_en, serial_clock_toggle} <= 4'h8;
    {port_wr_data, dir_wr_data} <= 16'h0000;
    apply(32'h0, 32'h0, 32'h0);
    do_reset();
    for (int i = 0; i < 400; i++) begin
      apply(xs(), xs(), xs());
      w = xs();
      write_settle(w[7:0], w[15:8]);
      if (i == 200) begin
        apply(xs(), xs(), xs());
        do_reset();
      end
    end
    $display("test random overrides done");
    // toggle pulses, one landing together with a write
    for (int k = 0; k < 24; k++) begin
      w = xs();
      @(posedge ref_clk);
      serial_clock_toggle <= w[0];
      port_wr_en <= (k == 9);
      port_wr_data <= w[15:8];
      if (k == 9) mport = w[15:8];
      if (w[0]) mport[4] = ~mport[4];
    end
    @(posedge ref_clk);
    {serial_clock_toggle, port_wr_en} <= 2'h0;
    repeat (8) @(posedge ref_clk);
    #1 compare_all();
    $display("test toggle done");
    // three-wire: bit6 set as input by software, bit2 input without pull-up
    @(posedge ref_clk);
    {serial_wire_mode_hi, serial_wire_mode_lo, spi_en} <= 3'h2;
    write_settle(8'h20, 8'h20);
    check("three_wire_out", {7'h00, pa_pad_out[5]},
          {7'h00, serial_data_out});
    $display("test three wire done");
    wrap_up();
  end
endmodule
